// *** src/lcdsd_pkg.sv ***
// Constants shared by the LCD segment driver
package lcdsd_pkg;
	localparam int SEG_COUNT      = 28;
	localparam int COM_COUNT      = 8;
	localparam int RAM_DEPTH      = 56;
	localparam int NIBBLE_W       = 4;
	localparam int POINTER_W      = 8;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [7:0] RAM_LAST      = 8'h37;
	// Sub-clock edge rate and alternation ratios
	localparam int SUB_CLOCK_HZ   = 32768;
	localparam logic [1:0] RATIO_RESET   = 2'h3;
	localparam int RATIO_BASE_LOG2 = 4;
	localparam int DIV_W          = 7;
	localparam int SYNC_STAGES    = 3;
endpackage : lcdsd_pkg

// *** src/lcdsd_alt_divider.sv ***
// Alternation clock divider running off the synchronised sub-clock
`timescale 1ns/100ps
module lcdsd_alt_divider (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic       sub_tick,
	input  wire logic [1:0] ratio_sel,
	output logic            alt_tick
);
	logic [lcdsd_pkg::DIV_W-1:0] count;
	logic [lcdsd_pkg::DIV_W-1:0] next_count;
	logic [lcdsd_pkg::DIV_W-1:0] limit;
	logic                        next_alt_tick;

	always_comb begin
		limit = lcdsd_pkg::DIV_W'((1 << (lcdsd_pkg::RATIO_BASE_LOG2
			+ int'(ratio_sel))) - 1);
		next_count = count;
		next_alt_tick = 1'b0;
		if (sub_tick) begin
			if (count >= limit) begin
				next_count = '0;
				next_alt_tick = 1'b1;
			end else begin
				next_count = count + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			count <= '0;
			alt_tick <= 1'b0;
		end else if (clk_en) begin
			count <= next_count;
			alt_tick <= next_alt_tick;
		end
	end
endmodule : lcdsd_alt_divider

// *** src/lcdsd_top.sv ***
// LCD segment driver: pattern memory, pointer, scan and pin drive
`timescale 1ns/100ps
module lcdsd_top (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        sub_clock,
	input  wire logic        hold_mode,
	input  wire logic [1:0]  ratio_sel,
	input  wire logic        display_on_command,
	input  wire logic        display_off_command,
	input  wire logic        pointer_low_half,
	input  wire logic        pointer_high_half,
	input  wire logic        memory_write,
	input  wire logic        memory_read,
	input  wire logic [3:0]  write_nibble,
	output logic [3:0]       read_nibble,
	output logic             read_valid,
	output logic             display_enabled,
	output logic             pump_enable,
	output logic [27:0]      segment_lines,
	output logic [7:0]       segment_active,
	output logic [7:0]       common_lines,
	output logic [7:0]       common_active,
	output logic             frame_polarity
);
	typedef enum logic {LCDSD_OFF, LCDSD_ON} lcdsd_disp_t;

	logic [lcdsd_pkg::SYNC_STAGES-1:0] sub_sync;
	logic        sub_level;
	logic        next_sub_level;
	logic        sub_tick;
	logic        alt_tick;

	lcdsd_disp_t disp_state;
	lcdsd_disp_t next_disp_state;
	logic [7:0]  display_ram_pointer;
	logic [7:0]  next_pointer;
	logic [3:0]  pattern_memory [lcdsd_pkg::RAM_DEPTH];
	logic [3:0]  next_read_nibble;
	logic        next_read_valid;
	logic        ptr_in_range;

	logic [2:0]  com_slot;
	logic [2:0]  next_com_slot;
	logic        polarity;
	logic        next_polarity;
	logic [27:0] next_seg;
	logic [7:0]  next_com;
	logic [27:0] seg_bits;

	// Sub-clock crosses in: second and third stages must agree
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sub_sync <= '0;
		end else if (clk_en) begin
			sub_sync <= {sub_sync[1:0], sub_clock};
		end
	end

	always_comb begin
		next_sub_level = sub_level;
		if (sub_sync[2] == sub_sync[1]) begin
			next_sub_level = sub_sync[2];
		end
	end

	// Rising edge only: one tick per sub-clock period
	assign sub_tick = next_sub_level & ~sub_level;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sub_level <= 1'b0;
		end else if (clk_en) begin
			sub_level <= next_sub_level;
		end
	end

	lcdsd_alt_divider u_div (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.sub_tick  (sub_tick),
		.ratio_sel (ratio_sel),
		.alt_tick  (alt_tick)
	);

	assign ptr_in_range = display_ram_pointer <= lcdsd_pkg::RAM_LAST;

	always_comb begin
		next_disp_state = disp_state;
		if (display_off_command) begin
			next_disp_state = LCDSD_OFF;
		end else if (display_on_command) begin
			next_disp_state = LCDSD_ON;
		end
		next_pointer = display_ram_pointer;
		if (pointer_low_half) begin
			next_pointer[3:0] = write_nibble;
		end
		if (pointer_high_half) begin
			next_pointer[7:4] = write_nibble;
		end
		next_read_valid = memory_read;
		next_read_nibble = read_nibble;
		if (memory_read) begin
			next_read_nibble = ptr_in_range
				? pattern_memory[display_ram_pointer[5:0]] : 4'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			disp_state <= LCDSD_OFF;
			display_ram_pointer <= lcdsd_pkg::POINTER_RESET;
			read_nibble <= 4'h0;
			read_valid <= 1'b0;
		end else if (clk_en) begin
			disp_state <= next_disp_state;
			display_ram_pointer <= next_pointer;
			read_nibble <= next_read_nibble;
			read_valid <= next_read_valid;
		end
	end

	// pattern memory, no reset to keep it a plain array
	always_ff @(posedge sys_clk) begin
		if (clk_en && memory_write && ptr_in_range) begin
			pattern_memory[display_ram_pointer[5:0]] <= write_nibble;
		end
	end

	genvar s;
	generate
		for (s = 0; s < lcdsd_pkg::SEG_COUNT; s++) begin : g_seg
			assign seg_bits[s] = com_slot[2]
				? pattern_memory[2*s+1][com_slot[1:0]]
				: pattern_memory[2*s][com_slot[1:0]];
		end
	endgenerate

	always_comb begin
		next_com_slot = com_slot;
		next_polarity = polarity;
		if (alt_tick) begin
			next_com_slot = com_slot + 3'h1;
			next_polarity = ~polarity;
		end
		next_seg = '0;
		next_com = '0;
		if (disp_state == LCDSD_ON) begin
			next_com = 8'h01 << com_slot;
			next_seg = seg_bits;
		end
	end

	// Lines carry lit/active plus polarity; analog bias levels lie outside
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			com_slot <= 3'h0;
			polarity <= 1'b0;
			segment_lines <= '0;
			segment_active <= '0;
			common_lines <= '0;
			common_active <= '0;
			frame_polarity <= 1'b0;
			display_enabled <= 1'b0;
			pump_enable <= 1'b0;
		end else if (clk_en) begin
			com_slot <= next_com_slot;
			polarity <= next_polarity;
			segment_lines <= next_seg ^ {28{polarity}};
			segment_active <= next_com;
			common_lines <= next_com ^ {8{polarity}};
			common_active <= next_com;
			frame_polarity <= polarity;
			display_enabled <= disp_state == LCDSD_ON;
			pump_enable <= disp_state == LCDSD_ON;
		end
	end

	// Hold mode does not gate the scan, so display stays lit
	logic unused_hold;
	assign unused_hold = hold_mode;
endmodule : lcdsd_top

// *** test/lcdsd_monitor.sv ***
// Port checker for the LCD segment driver
`timescale 1ns/100ps
module lcdsd_monitor (
	input wire logic	sys_clk,
	input wire logic	reset_n,
	input wire logic	display_on_command,
	input wire logic	display_off_command,
	input wire logic	memory_read,
	input wire logic	read_valid,
	input wire logic	display_enabled,
	input wire logic	pump_enable,
	input wire logic	frame_polarity,
	input wire logic [27:0]	segment_lines,
	input wire logic [7:0]	segment_active,
	input wire logic [7:0]	common_lines,
	input wire logic [7:0]	common_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_DARK: assert property (!display_enabled [*2] |->
		common_active == 8'h00 && segment_lines == {28{frame_polarity}})
		else $error("lit while off");
	AST_HOT: assert property ($onehot0(common_active))
		else $error("commons");
	AST_SEGACT: assert property (segment_active == common_active)
		else $error("segment slot");
	AST_POL: assert property (
		common_lines == (common_active ^ {8{frame_polarity}}))
		else $error("common drive");
	AST_PUMP: assert property (pump_enable == display_enabled)
		else $error("pump");
	AST_ON: assert property (
		display_on_command && !display_off_command |-> ##2 display_enabled)
		else $error("on");
	AST_OFF: assert property (
		display_off_command |-> ##2 !display_enabled)
		else $error("off");
	AST_RD: assert property (memory_read |=> read_valid)
		else $error("read valid");
	AST_FLIP: assert property (
		$past(common_active) != 8'h00 && common_active != 8'h00 &&
		$changed(frame_polarity) |-> $changed(common_active))
		else $error("flip");
endmodule : lcdsd_monitor
bind lcdsd_top lcdsd_monitor mon (.sys_clk, .reset_n, .display_on_command,
	.display_off_command, .memory_read, .read_valid, .display_enabled,
	.pump_enable, .frame_polarity, .segment_lines, .segment_active,
	.common_lines, .common_active);

// *** test/lcdsd_panel.sv ***
// Behavioural glass panel: keeps the last picture seen per common
`timescale 1ns/100ps
module lcdsd_panel (
	input wire logic	sys_clk,
	input wire logic [7:0]	com,
	input wire logic [27:0]	seg,
	input wire logic	pol,
	output logic [7:0][27:0]	pic
);
	// dot lit where seg matches the active com level, i.e. differs from pol
	always @(posedge sys_clk)
		for (int k = 0; k < 8; k++)
			if (com[k] != pol)
				pic[k] <= seg ^ {28{pol}};
endmodule : lcdsd_panel

// *** test/lcdsd_top_bench.sv ***
// Self-checking bench for the LCD segment driver
`timescale 1ns/100ps
module lcdsd_top_bench;
	typedef struct packed {logic [7:0] p; logic [3:0] d, e;} lcdsd_row_t;
	logic	sys_clk, reset_n, clk_en, hold_mode, p0;
	logic	sub_clock = 1'b0;
	logic	display_on_command, display_off_command, pointer_low_half;
	logic	pointer_high_half, memory_write, memory_read, read_valid;
	logic	display_enabled, pump_enable, frame_polarity;
	logic [1:0]	ratio_sel;
	logic [1:0]	sc = 2'h0;
	logic [3:0]	write_nibble, read_nibble, t;
	logic [5:0]	st;
	logic [7:0]	segment_active, common_lines, common_active, c0;
	logic [27:0]	segment_lines;
	logic [7:0][27:0]	pic, exp_pic;
	int	errors, checks, cyc, n;
	lcdsd_row_t	rows[5] = '{'{8'h00, 4'hA, 4'hA}, '{8'h01, 4'h5, 4'h5},
		'{8'h37, 4'h3, 4'h3}, '{8'h38, 4'hF, 4'h0}, '{8'hFF, 4'h9, 4'h0}};
	assign {display_on_command, display_off_command, pointer_low_half,
		pointer_high_half, memory_write, memory_read} = st;
	lcdsd_top uut (.sys_clk, .reset_n, .clk_en, .sub_clock, .hold_mode,
		.ratio_sel, .display_on_command, .display_off_command,
		.pointer_low_half, .pointer_high_half, .memory_write, .memory_read,
		.write_nibble, .read_nibble, .read_valid, .display_enabled,
		.pump_enable, .segment_lines, .segment_active, .common_lines,
		.common_active, .frame_polarity);
	lcdsd_panel panel (.sys_clk, .com(common_lines), .seg(segment_lines),
		.pol(frame_polarity), .pic);
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Fast sub-clock, eight system cycles a period, keeps runs short
	always @(posedge sys_clk) begin
		sc <= sc + 2'h1;
		if (sc == 2'h3)
			sub_clock <= ~sub_clock;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	function automatic logic [3:0] nib(int a);
		return 4'(a) ^ {2{2'(a >> 4)}};
	endfunction : nib
	task automatic cmp(string s, logic [223:0] e, logic [223:0] v);
		checks++;
		if (e !== v) begin
			errors++;
			$display("FAIL %s expected %0h seen %0h", s, e, v);
		end
	endtask : cmp
	task automatic op(logic [5:0] s, logic [3:0] d);
		@(posedge sys_clk);
		st <= s;
		write_nibble <= d;
		@(posedge sys_clk);
		st <= 6'h00;
	endtask : op
	task automatic acc(logic [7:0] p, logic [3:0] d, e);
		op(6'h08, p[3:0]);
		op(6'h04, p[7:4]);
		op(6'h02, d);
		op(6'h01, 4'h0);
		#1 cmp("read", e, read_nibble);
		cmp("valid", 1, read_valid);
	endtask : acc
	task automatic slot();
		c0 = common_active;
		p0 = frame_polarity;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (common_active === c0 && n < 3000);
	endtask : slot
	task automatic end_of_test();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		{reset_n, clk_en, hold_mode, st} = 9'h0C0;
		{ratio_sel, write_nibble} = 6'h00;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		foreach (rows[i]) acc(rows[i].p, rows[i].d, rows[i].e);
		$display("test table done");
		for (int a = 0; a < 56; a++) acc(8'(a), nib(a), nib(a));
		for (int k = 0; k < 8; k++)
			for (int m = 0; m < 28; m++) begin
				t = nib(2 * m + k / 4);
				exp_pic[k][m] = t[k % 4];
			end
		op(6'h20, 4'h0);
		for (int i = 0; i < 12; i++) begin
			slot();
			if (i > 1) begin
				cmp("slot", 128, n);
				cmp("order", {c0[6:0], c0[7]}, common_active);
				cmp("polarity", {~p0}, frame_polarity);
			end
		end
		cmp("dots", exp_pic, pic);
		// Enable low must freeze the scan for longer than one slot
		@(posedge sys_clk);
		clk_en <= 1'b0;
		@(negedge sys_clk);
		c0 = common_active;
		p0 = frame_polarity;
		repeat (300) @(negedge sys_clk);
		cmp("freeze", {c0, p0}, {common_active, frame_polarity});
		@(posedge sys_clk);
		clk_en <= 1'b1;
		$display("test scan done");
		for (int r = 1; r < 4; r++) begin
			@(posedge sys_clk);
			ratio_sel <= 2'(r);
			slot();
			slot();
			cmp("ratio", 128 << r, n);
		end
		$display("test ratio done");
		op(6'h10, 4'h0);
		repeat (4) @(negedge sys_clk);
		cmp("off", 0, common_active);
		op(6'h20, 4'h0);
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b0;
		@(posedge sys_clk);
		reset_n <= 1'b1;
		@(negedge sys_clk);
		cmp("reset", 0, {display_enabled, common_active});
		$display("test off done");
		end_of_test();
	end
endmodule : lcdsd_top_bench
